//--- src/asc_ctrl.sv
`timescale 1ns/100ps
module asc_ctrl (
  // clock and reset
  input  wire logic                        clk,
  input  wire logic                        srst,
  // user request
  input  wire logic                        req_valid,
  input  wire logic                        req_write,
  input  wire logic [asc_pkg::ADDR_W-1:0]  req_addr,
  input  wire logic [asc_pkg::DATA_W-1:0]  req_wdata,
  output logic                             req_ready,
  // user answer
  output logic                             rsp_valid,
  output logic      [asc_pkg::DATA_W-1:0]  rsp_rdata,
  // memory pins
  output logic      [asc_pkg::ADDR_W-1:0]  addr_in,
  output logic                             cs_n,
  output logic                             store_n,
  input  wire logic [asc_pkg::DATA_W-1:0]  nibble_io_i,
  output logic      [asc_pkg::DATA_W-1:0]  nibble_io_o,
  output logic                             nibble_io_oe
);
  asc_pkg::asc_state_e                state_ff;
  logic [asc_pkg::CNT_W-1:0]          cnt_ff;
  logic [asc_pkg::DATA_W-1:0]         rd_sync;

  ////////////////////////////////////////////////////////////////////////
  // the bus arrives from another chip, so it is sampled before use
  asc_sync #(.W(asc_pkg::DATA_W)) u_rd_sync (
    .clk   (clk),
    .srst  (srst),
    .d_in  (nibble_io_i),
    .d_out (rd_sync)
  );

  ////////////////////////////////////////////////////////////////////////
  // sequencer
  always_ff @(posedge clk) begin
    if (srst) begin
      state_ff <= asc_pkg::ASC_IDLE;
      cnt_ff   <= asc_pkg::CNT_ZERO;
    end else begin
      unique case (state_ff)
        asc_pkg::ASC_IDLE: begin
          if (req_valid && req_ready) begin
            if (req_write) begin
              state_ff <= asc_pkg::ASC_WR_SETUP;
              cnt_ff   <= asc_pkg::HZ_LOAD;
            end else begin
              // sampler latency added so the nibble seen is settled
              state_ff <= asc_pkg::ASC_RD_WAIT;
              cnt_ff   <= asc_pkg::RD_LOAD + asc_pkg::SYNC_LOAD;
            end
          end
        end
        asc_pkg::ASC_RD_WAIT: begin
          if (cnt_ff == asc_pkg::CNT_ONE) begin
            state_ff <= asc_pkg::ASC_TURN;
            cnt_ff   <= asc_pkg::HZ_LOAD;
          end else begin
            cnt_ff <= cnt_ff - asc_pkg::CNT_ONE;
          end
        end
        asc_pkg::ASC_WR_SETUP: begin
          // store_n low, device floats before data is driven
          if (cnt_ff == asc_pkg::CNT_ONE) begin
            state_ff <= asc_pkg::ASC_WR_PULSE;
            cnt_ff   <= asc_pkg::WP_LOAD;
          end else begin
            cnt_ff <= cnt_ff - asc_pkg::CNT_ONE;
          end
        end
        asc_pkg::ASC_WR_PULSE: begin
          if (cnt_ff == asc_pkg::CNT_ONE) begin
            state_ff <= asc_pkg::ASC_TURN;
            cnt_ff   <= asc_pkg::HZ_LOAD;
          end else begin
            cnt_ff <= cnt_ff - asc_pkg::CNT_ONE;
          end
        end
        asc_pkg::ASC_TURN: begin
          if (cnt_ff == asc_pkg::CNT_ONE) begin
            state_ff <= asc_pkg::ASC_IDLE;
            cnt_ff   <= asc_pkg::CNT_ZERO;
          end else begin
            cnt_ff <= cnt_ff - asc_pkg::CNT_ONE;
          end
        end
        default: begin
          state_ff <= asc_pkg::ASC_IDLE;
          cnt_ff   <= asc_pkg::CNT_ZERO;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pin drive
  always_ff @(posedge clk) begin
    if (srst) begin
      addr_in      <= asc_pkg::ADDR_RST;
      cs_n         <= 1'b1;
      store_n      <= 1'b1;
      nibble_io_o  <= asc_pkg::DATA_RST;
      nibble_io_oe <= 1'b0;
    end else begin
      unique case (state_ff)
        asc_pkg::ASC_IDLE: begin
          if (req_valid && req_ready) begin
            // address and store_n settle with cs_n, zero setup needed
            addr_in     <= req_addr;
            nibble_io_o <= req_wdata;
            cs_n        <= 1'b0;
            store_n     <= ~req_write;
          end
        end
        asc_pkg::ASC_RD_WAIT: begin
          nibble_io_oe <= 1'b0;
        end
        asc_pkg::ASC_WR_SETUP: begin
          if (cnt_ff == asc_pkg::CNT_ONE) begin
            nibble_io_oe <= 1'b1;
          end
        end
        asc_pkg::ASC_WR_PULSE: begin
          if (cnt_ff == asc_pkg::CNT_ONE) begin
            // store_n and cs_n rise together; data held one more cycle
            store_n <= 1'b1;
            cs_n    <= 1'b1;
          end
        end
        asc_pkg::ASC_TURN: begin
          cs_n         <= 1'b1;
          store_n      <= 1'b1;
          nibble_io_oe <= 1'b0;
        end
        default: begin
          cs_n         <= 1'b1;
          store_n      <= 1'b1;
          nibble_io_oe <= 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // user side
  always_ff @(posedge clk) begin
    if (srst) begin
      req_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_rdata <= asc_pkg::DATA_RST;
    end else begin
      rsp_valid <= 1'b0;
      if (state_ff == asc_pkg::ASC_IDLE && req_valid && req_ready) begin
        req_ready <= 1'b0;
      end else if (state_ff == asc_pkg::ASC_TURN && cnt_ff == asc_pkg::CNT_ONE) begin
        req_ready <= 1'b1;
      end else if (state_ff == asc_pkg::ASC_IDLE) begin
        req_ready <= 1'b1;
      end
      if (state_ff == asc_pkg::ASC_RD_WAIT && cnt_ff == asc_pkg::CNT_ONE) begin
        rsp_valid <= 1'b1;
        rsp_rdata <= rd_sync;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  AST_NO_DRIVE_IN_READ: assert property (@(posedge clk) disable iff (srst)
    (!cs_n && store_n) |-> !nibble_io_oe)
    else $error("bus driven during read");
  // data may stand one cycle past the write end, zero hold
  AST_DESELECT_IDLE: assert property (@(posedge clk) disable iff (srst)
    cs_n |-> (store_n && (!nibble_io_oe || !$past(store_n))))
    else $error("activity while deselected");
  AST_WRITE_PULSE: assert property (@(posedge clk) disable iff (srst)
    $fell(store_n) |-> (!store_n && !cs_n)[*2])
    else $error("write pulse too short");
  AST_DATA_BEFORE_END: assert property (@(posedge clk) disable iff (srst)
    ($rose(store_n) && !srst) |-> $past(nibble_io_oe))
    else $error("data not set up before write end");
  AST_ADDR_STABLE_WRITE: assert property (@(posedge clk) disable iff (srst)
    (!store_n && !$past(store_n)) |-> $stable(addr_in))
    else $error("address moved during write");
  AST_ADDR_HELD_SELECT: assert property (@(posedge clk) disable iff (srst)
    (!cs_n && !$past(cs_n)) |-> $stable(addr_in))
    else $error("address moved while selected");
  AST_DRIVE_AFTER_FLOAT: assert property (@(posedge clk) disable iff (srst)
    $rose(nibble_io_oe) |-> (!store_n && !$past(store_n)))
    else $error("bus driven before memory floated");
  AST_RSP_PULSE: assert property (@(posedge clk) disable iff (srst)
    rsp_valid |=> !rsp_valid)
    else $error("read answer held too long");
  AST_READ_LATENCY: assert property (@(posedge clk) disable iff (srst)
    (req_valid && req_ready && !req_write) |-> ##6 rsp_valid)
    else $error("read answer late");
  AST_TOGETHER_END: assert property (@(posedge clk) disable iff (srst)
    $rose(store_n) |-> cs_n)
    else $error("cs_n stayed low after write end");
  AST_STORE_NEEDS_CS: assert property (@(posedge clk) disable iff (srst)
    !store_n |-> !cs_n)
    else $error("store_n low while deselected");
endmodule

//--- src/asc_pkg.sv
package asc_pkg;
  localparam int unsigned ADDR_W     = 18;
  localparam int unsigned DATA_W     = 4;
  localparam int unsigned CLK_NS     = 100;
  // timing figures of the fastest grade, in ns
  localparam int unsigned T_WP_NS    = 9;
  localparam int unsigned T_DW_NS    = 5;
  localparam int unsigned T_AW_NS    = 9;
  localparam int unsigned T_WC_NS    = 10;
  localparam int unsigned T_RC_NS    = 10;
  localparam int unsigned T_AA_NS    = 10;
  localparam int unsigned T_CHZ_NS   = 5;
  localparam int unsigned T_WZ_NS    = 5;
  // least times round up, at least one cycle
  localparam int unsigned WP_CYC  = ((T_WP_NS + CLK_NS - 1) / CLK_NS) < 1 ? 1 :
                                    ((T_WP_NS + CLK_NS - 1) / CLK_NS);
  localparam int unsigned RD_CYC  = ((T_AA_NS + CLK_NS - 1) / CLK_NS) < 1 ? 1 :
                                    ((T_AA_NS + CLK_NS - 1) / CLK_NS);
  localparam int unsigned HZ_CYC  = ((T_CHZ_NS + CLK_NS - 1) / CLK_NS) < 1 ? 1 :
                                    ((T_CHZ_NS + CLK_NS - 1) / CLK_NS);
  localparam int unsigned CNT_W   = 4;
  localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
  localparam logic [CNT_W-1:0] CNT_ONE  = 4'h1;
  localparam logic [CNT_W-1:0] WP_LOAD  = CNT_W'(WP_CYC);
  localparam logic [CNT_W-1:0] RD_LOAD  = CNT_W'(RD_CYC);
  localparam logic [CNT_W-1:0] HZ_LOAD  = CNT_W'(HZ_CYC);
  // extra read wait so the three-stage sampler has settled
  localparam logic [CNT_W-1:0] SYNC_LOAD = 4'h4;
  localparam logic [ADDR_W-1:0] ADDR_RST = 18'h00000;
  localparam logic [DATA_W-1:0] DATA_RST = 4'h0;
  typedef enum logic [2:0] {
    ASC_IDLE,
    ASC_RD_WAIT,
    ASC_WR_SETUP,
    ASC_WR_PULSE,
    ASC_TURN
  } asc_state_e;
endpackage

//--- src/asc_sync.sv
`timescale 1ns/100ps
// three-stage input sampler; a change counts once stages two and three agree
module asc_sync #(
  parameter int unsigned W = 4
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         srst,
  // data
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] d_out
);
  logic [W-1:0] s1_ff;
  logic [W-1:0] s2_ff;
  logic [W-1:0] s3_ff;

  always_ff @(posedge clk) begin
    if (srst) begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
      d_out <= '0;
    end else begin
      s1_ff <= d_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      if (s2_ff == s3_ff) begin
        d_out <= s3_ff;
      end
    end
  end
endmodule

//--- testbench/asc_sram_model.sv
`timescale 1ns/100ps
// far-side memory; the bus level of both parties is resolved here
module asc_sram_model (
  // pins
  input  wire logic                       clk,
  input  wire logic [asc_pkg::ADDR_W-1:0] addr_in,
  input  wire logic                       cs_n,
  input  wire logic                       store_n,
  input  wire logic                       slow,
  // controller side of the bus
  input  wire logic [asc_pkg::DATA_W-1:0] ctrl_d,
  input  wire logic                       ctrl_oe,
  output logic      [asc_pkg::DATA_W-1:0] bus,
  output logic                            clash
);
  logic [3:0] mem [0:262143];
  logic [3:0] q;
  logic [3:0] last = 4'h5;
  logic       q_oe;
  wire        rd = !cs_n && store_n;
  wire        wr = !cs_n && !store_n;
  // output on 3 ns after select, off within 2 ns
  assign #(3, 2) q_oe = rd;
  // old data held 3 ns, then garbage until access time
  always @(addr_in, cs_n, store_n) begin
    q <= #3 ~q;
    q <= #(slow ? 10 : 4) mem[addr_in];
  end
  // capture at the end of the overlap, zero hold
  always @(negedge wr) begin
    mem[addr_in] <= bus;
  end
  ////////////////////
  // a floating bus flips every cycle so stale values never pass
  assign bus = ctrl_oe ? ctrl_d : (q_oe ? q : ~last);
  initial clash = 1'b0;
  always @(posedge clk) begin
    last <= bus;
    if (ctrl_oe === 1'b1 && q_oe === 1'b1) begin
      clash <= 1'b1;
    end
  end
endmodule

//--- testbench/async_sram_256k_x4_tb.sv
`timescale 1ns/100ps
module async_sram_256k_x4_tb;
  logic        clk       = 1'b0;
  logic        srst      = 1'b1;
  logic        req_valid = 1'b0;
  logic        req_write = 1'b0;
  logic        slow      = 1'b0;
  logic [17:0] req_addr  = 18'h00000;
  logic [3:0]  req_wdata = 4'h0;
  logic [31:0] lfsr_st   = 32'h18E8;
  logic [3:0]  refm [logic [17:0]];
  logic        req_ready, rsp_valid, cs_n, store_n, oe, clash;
  logic [3:0]  rsp_rdata, dq_o, bus;
  logic [17:0] addr_in;
  int          miscompares = 0;
  int          num_checks  = 0;

  always #50 clk = ~clk;

  asc_ctrl uut (.clk(clk), .srst(srst), .req_valid(req_valid), .req_write(req_write),
    .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .addr_in(addr_in), .cs_n(cs_n),
    .store_n(store_n), .nibble_io_i(bus), .nibble_io_o(dq_o), .nibble_io_oe(oe));
  asc_sram_model mdl (.clk(clk), .addr_in(addr_in), .cs_n(cs_n), .store_n(store_n),
    .slow(slow), .ctrl_d(dq_o), .ctrl_oe(oe), .bus(bus), .clash(clash));

  ////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // {cs_n, store_n, oe, req_ready, rsp_valid} as seen at edge n after the taking edge
  function automatic logic [4:0] pins_exp(input logic wr, input int n);
    if (wr) return (n == 1) ? 5'h00 : (n == 2) ? 5'h04 : (n == 3) ? 5'h1C : 5'h1A;
    return (n < 6) ? 5'h08 : (n == 6) ? 5'h09 : 5'h1A;
  endfunction

  task automatic chk(input logic [17:0] got, input logic [17:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic complete_run;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // one request, pins followed cycle by cycle
  task automatic access(input logic wr, input logic [17:0] a, input logic [3:0] d);
    logic [4:0] e;
    int         n;
    n = 0;
    while (req_ready !== 1'b1) begin
      @(negedge clk);
      n++;
      if (n > 20) begin
        miscompares++;
        complete_run();
      end
    end
    req_valid = 1'b1;
    req_write = wr;
    req_addr  = a;
    req_wdata = d;
    @(negedge clk);
    req_valid = 1'b0;
    // pins read half a cycle before edge n
    for (n = 1; n <= (wr ? 4 : 8); n++) begin
      e = pins_exp(wr, n);
      chk({cs_n, store_n, oe, req_ready, rsp_valid}, e);
      if (!e[4]) chk(addr_in, a);
      if (e[2]) chk(bus, d);
      if (e[0]) chk(rsp_rdata, refm[a]);
      @(negedge clk);
    end
    if (wr) refm[a] = d;
  endtask

  ////////////////////
  initial begin
    logic [17:0] a;
    repeat (5) @(negedge clk);
    srst = 1'b0;
    @(negedge clk);
    chk({cs_n, store_n, oe}, 3'h6);
    $display("test reset done");
    // both address ends, overwrite, slow memory
    slow = 1'b1;
    access(1'b1, 18'h00000, 4'hA);
    access(1'b1, 18'h3FFFF, 4'h5);
    access(1'b0, 18'h00000, 4'h0);
    access(1'b1, 18'h3FFFF, 4'hF);
    access(1'b0, 18'h3FFFF, 4'h0);
    $display("test corners done");
    // small pool so reads hit rewritten words
    for (int i = 0; i < 40; i++) begin
      lfsr_st = lfsr(lfsr_st);
      slow = lfsr_st[7];
      a = {lfsr_st[20] ? 14'h3FFF : 14'h0000, lfsr_st[3:0]};
      if (lfsr_st[5] && refm.exists(a)) access(1'b0, a, 4'h0);
      else access(1'b1, a, lfsr_st[11:8]);
    end
    $display("test random done");
    chk(clash, 1'b0);
    complete_run();
  end
endmodule
